// >>> adc_seq_irq_ctrl.sv
// Interrupt flags, sequencer control, sequencer status and interval timer.
// Assumes the conversion datapath reports events as one-cycle strobes and
// that register requests last one cycle; read data follows one cycle later.
module adc_seq_irq_ctrl #(
	parameter int TICK_CYCLES = adc_seq_pkg::TICK_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire adc_seq_pkg::reg_req_t reg_req,
	input  wire logic [15:0]           channel_gain_control,
	input  wire adc_seq_pkg::adc_ev_t  adc_ev,
	input  wire adc_seq_pkg::seq_ev_t  seq_ev,
	input  wire logic                  convert_wr,
	output logic [15:0]                rdata_q,
	output logic                       irq_q,
	output logic                       seq_start_q,
	output logic                       seq_active_q,
	output logic                       convert_start_q
);
	import adc_seq_pkg::*;

	function automatic logic wr_hit(input reg_req_t r, input logic [7:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction

	function automatic logic rd_hit(input reg_req_t r, input logic [7:0] ofs);
		return r.rd && (r.addr == ofs);
	endfunction

	seq_state_t  state_q;
	seq_state_t  state_d;
	logic        run_q;
	logic        irq_en_q;
	logic [15:0] interval_q;
	logic [1:0]  if_q;
	logic [3:0]  sf_q;
	logic [3:0]  sf_eff;
	logic [1:0]  if_set;
	logic [1:0]  if_clr;
	logic [3:0]  sf_set;
	logic [3:0]  sf_clr;
	logic        wr_int;
	logic        wr_ctl;
	logic        wr_flags;
	logic        wr_ival;
	logic        start_req;
	logic        continuous;
	logic        err_any;
	logic        expire;
	logic        seq_start_d;
	logic        iram_set;
	logic        tmr_set;
	logic        ovf_set;
	logic        avail_set;
	logic        run_clr;
	logic        pend_now;
	logic        irq_d;
	logic [15:0] rdata_d;

	// Register write decode
	assign wr_int   = wr_hit(reg_req, INTFLAGS_OFS);
	assign wr_ctl   = wr_hit(reg_req, SEQCTRL_OFS);
	assign wr_flags = wr_hit(reg_req, SEQFLAGS_OFS);
	assign wr_ival  = wr_hit(reg_req, INTERVAL_OFS);

	// A start is only taken from idle; a stopping sequence just keeps going
	assign start_req  = wr_ctl && reg_req.wdata[CTL_RUN_BIT] && (state_q == ST_IDLE);
	assign continuous = (interval_q == 16'h0000);

	// Error flags that would be hidden in continuous mode also never act
	always_comb begin
		sf_eff = sf_q;
		if (continuous) begin
			sf_eff[SF_TMR_BIT] = 1'b0;
			sf_eff[SF_OVF_BIT] = 1'b0;
		end
	end

	assign err_any  = |sf_eff[SF_IRAM_BIT:SF_OVF_BIT];
	assign pend_now = irq_en_q && err_any;

	// Interval timer, restarted by every sequence start
	interval_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.clk      (clk),
		.reset    (reset),
		.restart  (seq_start_d),
		.interval (interval_q),
		.expire   (expire)
	);

	// Sequence completion and in-run timer expiry effects on the status flags
	assign avail_set = seq_ev.last_done && (state_q == ST_RUN);
	assign ovf_set   = avail_set && sf_q[SF_AVAIL_BIT] && !continuous;
	assign tmr_set   = expire && (state_q == ST_RUN) && !continuous;

	// Sequencer state machine
	always_comb begin
		state_d     = state_q;
		seq_start_d = 1'b0;
		iram_set    = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (start_req) begin
					if (seq_ev.instr_valid) begin
						seq_start_d = 1'b1;
						state_d     = ST_RUN;
					end else begin
						iram_set = 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (seq_ev.last_done) begin
					if (!run_q || err_any || tmr_set || ovf_set) begin
						state_d = ST_IDLE;
					end else if (continuous) begin
						if (seq_ev.instr_valid) begin
							seq_start_d = 1'b1;
						end else begin
							iram_set = 1'b1;
							state_d  = ST_IDLE;
						end
					end else begin
						state_d = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (!run_q || err_any) begin
					state_d = ST_IDLE;
				end else if (expire) begin
					if (seq_ev.instr_valid) begin
						seq_start_d = 1'b1;
						state_d     = ST_RUN;
					end else begin
						iram_set = 1'b1;
						state_d  = ST_IDLE;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Halting drops the run bit so software has to start again
	assign run_clr = iram_set || ((state_q != ST_IDLE) && (state_d == ST_IDLE));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Sequencer control register; a hardware halt wins over a same-cycle write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			run_q    <= SEQCTRL_RST[CTL_RUN_BIT];
			irq_en_q <= SEQCTRL_RST[CTL_IRQEN_BIT];
		end else begin
			if (run_clr) begin
				run_q <= 1'b0;
			end else if (wr_ctl) begin
				run_q <= reg_req.wdata[CTL_RUN_BIT];
			end
			if (wr_ctl) begin
				irq_en_q <= reg_req.wdata[CTL_IRQEN_BIT];
			end
		end
	end

	// Interval register, full 16 bits read/write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			interval_q <= INTERVAL_RST;
		end else if (wr_ival) begin
			interval_q <= reg_req.wdata;
		end
	end

	// Conversion and settling flags follow the channel/gain enables
	assign if_set[INT_CONV_BIT]   = adc_ev.conv_done && channel_gain_control[GAIN_IRQEN_BIT];
	assign if_set[INT_SETTLE_BIT] = adc_ev.settle_done && channel_gain_control[GAIN_IRQEN_BIT]
		&& !channel_gain_control[GAIN_AUTO_BIT];
	assign if_clr = wr_int ? reg_req.wdata[1:0] : 2'b00;

	sticky_flags #(
		.N (2)
	) u_int_flags (
		.clk   (clk),
		.reset (reset),
		.set   (if_set),
		.clr   (if_clr),
		.q     (if_q)
	);

	// Sequencer status flags, all write-one-to-clear
	assign sf_set = {iram_set, tmr_set, ovf_set, avail_set};
	assign sf_clr = wr_flags ? reg_req.wdata[3:0] : 4'h0;

	sticky_flags #(
		.N (4)
	) u_seq_flags (
		.clk   (clk),
		.reset (reset),
		.set   (sf_set),
		.clr   (sf_clr),
		.q     (sf_q)
	);

	// Interrupt line: held as long as any enabled condition is pending
	assign irq_d = (|if_q) || (irq_en_q && (|sf_eff));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// Sequencer strobes and single-conversion gate toward the datapath
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			seq_start_q     <= 1'b0;
			seq_active_q    <= 1'b0;
			convert_start_q <= 1'b0;
		end else begin
			seq_start_q     <= seq_start_d;
			seq_active_q    <= (state_d != ST_IDLE);
			convert_start_q <= convert_wr && !run_q;
		end
	end

	// Read mux; unmapped offsets and reserved bits read zero
	always_comb begin
		case (reg_req.addr)
			INTFLAGS_OFS: rdata_d = {13'h0000, pend_now, if_q};
			SEQCTRL_OFS:  rdata_d = {14'h0000, irq_en_q, run_q};
			SEQFLAGS_OFS: rdata_d = {12'h000, sf_eff};
			INTERVAL_OFS: rdata_d = interval_q;
			default:      rdata_d = 16'h0000;
		endcase
	end

	// Read data holds until the next read
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_q <= 16'h0000;
		end else if (reg_req.rd) begin
			rdata_q <= rdata_d;
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence start_write_s;
		wr_ctl && reg_req.wdata[CTL_RUN_BIT] && (state_q == ST_IDLE);
	endsequence

	sequence good_start_s;
		start_write_s ##0 seq_ev.instr_valid;
	endsequence

	sequence bad_start_s;
		start_write_s ##0 !seq_ev.instr_valid;
	endsequence

	sequence cont_done_s;
		(state_q == ST_RUN) && seq_ev.last_done && run_q && !err_any && continuous
			&& seq_ev.instr_valid;
	endsequence

	pend_read_a: assert property (rd_hit(reg_req, INTFLAGS_OFS)
		|=> rdata_q[INT_PEND_BIT] == ($past(irq_en_q) && (($past(sf_eff) & 4'he) != 4'h0)))
		else $error("pending bit does not match enabled error flags");

	settle_set_a: assert property (adc_ev.settle_done && channel_gain_control[GAIN_IRQEN_BIT]
		&& !channel_gain_control[GAIN_AUTO_BIT] |=> if_q[INT_SETTLE_BIT])
		else $error("settling flag not set");

	conv_set_a: assert property (adc_ev.conv_done && channel_gain_control[GAIN_IRQEN_BIT]
		|=> if_q[INT_CONV_BIT] ##1 irq_q)
		else $error("conversion flag or interrupt not raised");

	conv_clear_a: assert property (wr_int && reg_req.wdata[INT_CONV_BIT] && !adc_ev.conv_done
		|=> !if_q[INT_CONV_BIT])
		else $error("conversion flag not cleared by write one");

	seq_irq_a: assert property (irq_en_q && (|sf_eff) |=> irq_q)
		else $error("enabled sequencer flag raised no interrupt");

	seq_quiet_a: assert property (!irq_en_q && (if_q == 2'b00) |=> !irq_q)
		else $error("interrupt raised with nothing enabled pending");

	start_now_a: assert property (good_start_s |=> seq_start_q && seq_active_q ##1 !seq_start_q)
		else $error("sequencer did not start at once");

	stop_finish_a: assert property ((state_q == ST_RUN) && !run_q && !seq_ev.last_done
		|=> seq_active_q)
		else $error("sequence aborted before its last instruction");

	iram_err_a: assert property (bad_start_s |=> sf_q[SF_IRAM_BIT] && !seq_active_q && !run_q)
		else $error("missing instruction error not flagged");

	timer_err_a: assert property ((state_q == ST_RUN) && expire && !continuous
		|=> sf_q[SF_TMR_BIT])
		else $error("timer error not flagged");

	cont_mask_a: assert property (continuous && rd_hit(reg_req, SEQFLAGS_OFS)
		|=> rdata_q[2:1] == 2'b00)
		else $error("error bits visible in continuous mode");

	overflow_a: assert property ((state_q == ST_RUN) && seq_ev.last_done && sf_q[SF_AVAIL_BIT]
		&& !continuous |=> sf_q[SF_OVF_BIT] && sf_q[SF_AVAIL_BIT])
		else $error("overflow or data flag missing");

	err_halt_a: assert property ((state_q != ST_IDLE) && err_any ##0 seq_ev.last_done
		|=> (!seq_active_q && !run_q) [*2])
		else $error("sequencer kept running with an error flag");

	cont_restart_a: assert property (cont_done_s |=> seq_start_q)
		else $error("continuous mode did not restart");

	conv_gate_a: assert property (run_q && convert_wr |=> !convert_start_q)
		else $error("single conversion passed while sequencing");

	// Timed mode: expiry in the wait state must launch the next sequence
	wait_restart_a: assert property ((state_q == ST_WAIT) && run_q && !err_any && expire
		&& seq_ev.instr_valid |=> seq_start_q && seq_active_q)
		else $error("interval expiry did not restart the sequence");

	// A restart with an empty instruction memory must stop with an error
	restart_iram_a: assert property ((state_q == ST_RUN) && seq_ev.last_done && run_q && !err_any
		&& continuous && !seq_ev.instr_valid |=> sf_q[SF_IRAM_BIT] && !seq_active_q)
		else $error("restart without instruction not flagged");

	// Automatic settling never reports a settling event
	settle_auto_a: assert property (adc_ev.settle_done && channel_gain_control[GAIN_AUTO_BIT]
		&& !if_q[INT_SETTLE_BIT] |=> !if_q[INT_SETTLE_BIT])
		else $error("settling flag set in automatic mode");

endmodule

// >>> adc_seq_pkg.sv
// Constants, register map and carrier types for the sequencer and interrupt control.
// Assumes a 250 MHz clock and a 16-bit local register port on the host side.
// What this block does
// - Pending bit two reads enabled sequencer errors
// - Settling done sets flag when enabled, manual
// - Conversion done sets flag when interrupts enabled
// - Write one clears interrupt flag, zero keeps
// - Enabled sequencer flags raise the interrupt line
// - Run bit set starts sequencer at once
// - Run bit cleared finishes current sequence first
// - Start without valid instruction sets memory error
// - Timer expiry during running sequence flags error
// - Continuous mode hides the timer error
// - Completion with unread results flags overflow
// - Continuous mode hides the overflow error
// - Each completed sequence sets results available
// - Sequencer flags clear by writing one
// - Any error halts after the last instruction
// - Interval is sixteen bits of 100us
// - Interval expiry starts sequence from first instruction
// - Zero interval restarts right after completion
// - Convert writes ignored while run bit set
package adc_seq_pkg;

	// Register offsets on the local register port
	localparam logic [7:0] INTFLAGS_OFS = 8'h08;
	localparam logic [7:0] SEQCTRL_OFS  = 8'h0a;
	localparam logic [7:0] SEQFLAGS_OFS = 8'h0c;
	localparam logic [7:0] INTERVAL_OFS = 8'h0e;

	// Field positions
	localparam int INT_CONV_BIT   = 0;
	localparam int INT_SETTLE_BIT = 1;
	localparam int INT_PEND_BIT   = 2;
	localparam int CTL_RUN_BIT    = 0;
	localparam int CTL_IRQEN_BIT  = 1;
	localparam int SF_AVAIL_BIT   = 0;
	localparam int SF_OVF_BIT     = 1;
	localparam int SF_TMR_BIT     = 2;
	localparam int SF_IRAM_BIT    = 3;
	localparam int GAIN_IRQEN_BIT = 10;
	localparam int GAIN_AUTO_BIT  = 8;

	// Reset values
	localparam logic [15:0] INTFLAGS_RST = 16'h0000;
	localparam logic [15:0] SEQCTRL_RST  = 16'h0000;
	localparam logic [15:0] SEQFLAGS_RST = 16'h0000;
	localparam logic [15:0] INTERVAL_RST = 16'h0000;

	// Timing: one interval unit is 100 us
	localparam int CLK_PERIOD_NS  = 4;
	localparam int TICK_PERIOD_NS = 100000;
	localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic conv_done;
		logic settle_done;
	} adc_ev_t;

	typedef struct packed {
		logic last_done;
		logic instr_valid;
	} seq_ev_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_WAIT = 2'b10
	} seq_state_t;

endpackage

// >>> sticky_flags.sv
// A row of sticky flags: hardware sets, software clears by writing one.
// Assumes set and clear are single-cycle strobes in the clk domain.
module sticky_flags #(
	parameter int N = 4
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [N-1:0] set,
	input  wire logic [N-1:0] clr,
	output logic      [N-1:0] q
);

	// Set wins over clear so an event in the clearing cycle is kept
	for (genvar i = 0; i < N; i++) begin : g_flag
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				q[i] <= 1'b0;
			end else if (set[i]) begin
				q[i] <= 1'b1;
			end else if (clr[i]) begin
				q[i] <= 1'b0;
			end
		end
	end

endmodule

// >>> interval_timer.sv
// Sequence interval timer: 100 us prescaler and a 16-bit unit counter.
// Assumes restart pulses at each sequence start; a zero interval never expires.
module interval_timer #(
	parameter int TICK_CYCLES = adc_seq_pkg::TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        restart,
	input  wire logic [15:0] interval,
	output logic             expire
);
	import adc_seq_pkg::*;

	logic [31:0] pre_q;
	logic [15:0] units_q;
	logic        tick;

	assign tick = (pre_q == 32'(TICK_CYCLES - 1));

	// Prescaler restarts with the sequence so the first unit is a full one
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pre_q <= 32'h0000_0000;
		end else if (restart || tick) begin
			pre_q <= 32'h0000_0000;
		end else begin
			pre_q <= pre_q + 32'h0000_0001;
		end
	end

	// Unit counter; expiry rearms itself for the next interval
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			units_q <= 16'h0000;
			expire  <= 1'b0;
		end else if (restart) begin
			units_q <= 16'h0000;
			expire  <= 1'b0;
		end else if (tick && interval != 16'h0000) begin
			if (units_q + 16'h0001 >= interval) begin
				units_q <= 16'h0000;
				expire  <= 1'b1;
			end else begin
				units_q <= units_q + 16'h0001;
				expire  <= 1'b0;
			end
		end else begin
			expire <= 1'b0;
		end
	end

endmodule

// >>> seq_engine_model.sv
// Behavioural model of the sequencer engine behind the control block.
// Assumes seq_start is a one-cycle pulse; it answers with last_done after seq_len cycles.
module seq_engine_model
	import adc_seq_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       seq_start,
	input  wire logic       instr_ok,
	input  wire logic [7:0] seq_len,
	output seq_ev_t         seq_ev
);
	logic [7:0] left_q;
	logic       last_q;

	// One driver for the whole struct; validity is a level the bench chooses
	assign seq_ev = '{last_done: last_q, instr_valid: instr_ok};

	// Run one sequence; a start mid-sequence restarts from the first instruction
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			left_q <= 8'h00;
			last_q <= 1'b0;
		end else begin
			last_q <= (left_q == 8'h01);
			if (seq_start)
				left_q <= seq_len;
			else if (left_q != 8'h00)
				left_q <= left_q - 8'h01;
		end
	end
endmodule

// >>> tb_adc_seq_irq_ctrl.sv
// Self-checking bench for the sequencer and interrupt control block.
// Assumes a shortened 100 us prescaler (TICKS) and the engine model as datapath.
module tb_adc_seq_irq_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_seq_pkg::*;
	localparam int TICKS = 4;
	logic        clk;
	logic        reset;
	reg_req_t    reg_req;
	logic [15:0] gain;
	adc_ev_t     adc_ev;
	seq_ev_t     seq_ev;
	logic        convert_wr;
	logic        instr_ok;
	logic [7:0]  seq_len;
	logic [15:0] rdata_q;
	logic        irq_q;
	logic        seq_start_q;
	logic        seq_active_q;
	logic        convert_start_q;
	int          fails;
	int          comparisons;
	int          starts;
	int          dones;
	int          s0;

	adc_seq_irq_ctrl #(.TICK_CYCLES(TICKS)) i_adc_seq_irq_ctrl (.clk(clk), .reset(reset),
		.reg_req(reg_req), .channel_gain_control(gain), .adc_ev(adc_ev), .seq_ev(seq_ev),
		.convert_wr(convert_wr), .rdata_q(rdata_q), .irq_q(irq_q), .seq_start_q(seq_start_q),
		.seq_active_q(seq_active_q), .convert_start_q(convert_start_q));

	seq_engine_model i_seq_engine_model (.clk(clk), .reset(reset), .seq_start(seq_start_q),
		.instr_ok(instr_ok), .seq_len(seq_len), .seq_ev(seq_ev));

	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Count starts and completions away from the active edge
	always @(negedge clk) begin
		if (seq_start_q === 1'b1) starts++;
		if (seq_ev.last_done === 1'b1) dones++;
	end

	task automatic end_of_test();
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		cycles(1);
		reg_req = '0;
	endtask

	// Read data is registered on the request edge
	task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp, input string msg);
		@(posedge clk);
		#1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		cycles(1);
		reg_req = '0;
		check(rdata_q, exp, msg);
	endtask

	// 0 conversion done, 1 settling done, other convert write
	task automatic strobe(input int which);
		@(posedge clk);
		#1;
		case (which)
			0: adc_ev.conv_done = 1'b1;
			1: adc_ev.settle_done = 1'b1;
			default: convert_wr = 1'b1;
		endcase
		cycles(1);
		adc_ev = '0;
		convert_wr = 1'b0;
	endtask

	task automatic wait_idle(input int lim);
		int i;
		for (i = 0; i < lim && seq_active_q !== 1'b0; i++) cycles(1);
		check({15'h0, seq_active_q}, 16'h0000, "sequencer halted");
	endtask

	// Watchdog, far beyond the expected few hundred cycles
	initial begin
		#200000;
		fails++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		reset = 1'b1;
		reg_req = '0;
		gain = 16'h0000;
		adc_ev = '0;
		convert_wr = 1'b0;
		instr_ok = 1'b0;
		seq_len = 8'h05;
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		reg_rd(INTFLAGS_OFS, INTFLAGS_RST, "interrupt flags reset");
		reg_rd(SEQCTRL_OFS, SEQCTRL_RST, "control reset");
		reg_rd(SEQFLAGS_OFS, SEQFLAGS_RST, "sequencer flags reset");
		reg_rd(8'h10, 16'h0000, "unmapped read");
		$display("test reset values done");

		strobe(0); // Interrupts disabled: no conversion flag
		reg_rd(INTFLAGS_OFS, 16'h0000, "conv flag disabled");
		gain = 16'h0500;
		strobe(1);
		reg_rd(INTFLAGS_OFS, 16'h0000, "settle flag in auto mode");
		gain = 16'h0400;
		strobe(1);
		strobe(0);
		cycles(1);
		check({15'h0, irq_q}, 16'h0001, "irq on flags");
		reg_rd(INTFLAGS_OFS, 16'h0003, "conv and settle flags");
		reg_wr(INTFLAGS_OFS, 16'h0000);
		reg_rd(INTFLAGS_OFS, 16'h0003, "write zero keeps");
		reg_wr(INTFLAGS_OFS, 16'h0001);
		reg_rd(INTFLAGS_OFS, 16'h0002, "write one clears conv");
		reg_wr(INTFLAGS_OFS, 16'h0002);
		cycles(2);
		check({15'h0, irq_q}, 16'h0000, "irq released");
		gain = 16'h0000;
		$display("test interrupt flags done");

		reg_wr(SEQCTRL_OFS, 16'h0003); // No valid instruction
		reg_rd(SEQFLAGS_OFS, 16'h0008, "instruction memory error");
		reg_rd(INTFLAGS_OFS, 16'h0004, "sequencer pending");
		reg_rd(SEQCTRL_OFS, 16'h0002, "run bit cleared");
		check({15'h0, irq_q}, 16'h0001, "sequencer irq");
		reg_wr(SEQFLAGS_OFS, 16'h0008);
		reg_rd(SEQFLAGS_OFS, 16'h0000, "error cleared");
		reg_rd(INTFLAGS_OFS, 16'h0000, "pending gone");
		reg_wr(SEQCTRL_OFS, 16'h0000);
		$display("test start error done");

		instr_ok = 1'b1;
		s0 = starts;
		reg_wr(SEQCTRL_OFS, 16'h0001);
		check({14'h0, seq_start_q, seq_active_q}, 16'h0003, "immediate start");
		strobe(2);
		check({15'h0, convert_start_q}, 16'h0000, "convert ignored");
		cycles(30);
		check(16'(starts - s0 >= 4), 16'h0001, "continuous restarts");
		reg_rd(SEQFLAGS_OFS, 16'h0001, "no overflow when continuous");
		check({15'h0, irq_q}, 16'h0000, "sequencer irq disabled");
		reg_wr(SEQCTRL_OFS, 16'h0000);
		wait_idle(40);
		check(16'(starts - dones), 16'h0000, "last sequence finished");
		strobe(2);
		check({15'h0, convert_start_q}, 16'h0001, "convert passed");
		reg_wr(SEQFLAGS_OFS, 16'h000f);
		$display("test continuous done");

		reg_wr(INTERVAL_OFS, 16'h0003);
		reg_rd(INTERVAL_OFS, 16'h0003, "interval readback");
		s0 = starts;
		reg_wr(SEQCTRL_OFS, 16'h0003);
		cycles(9);
		check(16'(starts - s0), 16'h0001, "waits for interval");
		wait_idle(60);
		check(16'(starts - s0), 16'h0002, "restart on expiry");
		reg_rd(SEQFLAGS_OFS, 16'h0003, "overflow and available");
		reg_rd(SEQCTRL_OFS, 16'h0002, "halt on overflow");
		reg_rd(INTFLAGS_OFS, 16'h0004, "pending on overflow");
		check({15'h0, irq_q}, 16'h0001, "irq on overflow");
		reg_wr(SEQFLAGS_OFS, 16'h000f);
		$display("test timed sequence done");

		seq_len = 8'h14;
		reg_wr(INTERVAL_OFS, 16'h0001);
		s0 = starts;
		reg_wr(SEQCTRL_OFS, 16'h0001);
		wait_idle(60);
		check(16'(starts - s0), 16'h0001, "no restart after error");
		reg_rd(SEQFLAGS_OFS, 16'h0005, "timer error");
		reg_wr(INTERVAL_OFS, 16'h0000);
		reg_rd(SEQFLAGS_OFS, 16'h0001, "timer error hidden");
		reg_wr(SEQFLAGS_OFS, 16'h000f);
		reg_rd(SEQFLAGS_OFS, 16'h0000, "all cleared");
		$display("test timer error done");

		reg_wr(SEQCTRL_OFS, 16'h0001);
		instr_ok = 1'b0; // Instructions vanish before the continuous restart
		wait_idle(60);
		reg_rd(SEQFLAGS_OFS, 16'h0009, "restart without instruction");
		reg_rd(SEQCTRL_OFS, 16'h0000, "run cleared on restart error");
		$display("test restart error done");
		end_of_test();
	end
endmodule
